// ===== verilog/dma_channel_ctrl.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module dma_channel_ctrl
  import dma_status_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
)
(
  input wire logic CLOCK_I, // 250 MHz clock
  input wire logic RST_B_I, // async reset, low
  input wire logic [7:0] ADDR_I, // register byte address
  input wire logic [31:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  output logic [31:0] RDATA_O, // read data, cycle after RD_I
  input wire logic [NCH-1:0] START_EV_I, // start event per channel
  input wire logic [NCH-1:0] ABORT_EV_I, // abort event per channel
  input wire logic BEAT_DONE_I, // granted channel finished a beat
  input wire logic BEAT_READ_I, // that beat was a read
  input wire logic [31:0] BEAT_ADDR_I, // that beat's address
  input wire logic BLOCK_DONE_I, // that beat ended the block
  output logic GNT_VALID_O, // a channel owns the bus
  output logic [2:0] GNT_CH_O, // owning channel
  output logic [NCH-1:0] BUSY_O // per-channel active flag
);
  // index fields are three bits wide and chaining needs two channels
  if (NCH < 2 || NCH > 8)
  begin : g_bad_nch
    $error("channel count must be 2..8");
  end
  // ==========================================================
  // channel state
  // ==========================================================
  logic [NCH-1:0] on_r;
  logic [NCH-1:0] xfer_r;
  logic [NCH-1:0] seen_r;
  logic [NCH-1:0] chain_dir_r;
  logic [NCH-1:0] evoff_r;
  logic [NCH-1:0] permit_r;
  logic [NCH-1:0] auto_r;
  logic [2*NCH-1:0] rank_r;
  logic [NCH-1:0] done_pulse;
  logic [NCH-1:0] ctl_wr;
  logic [NCH-1:0] req;
  logic gnt_valid;
  logic [2:0] gnt_idx;
  logic owner_r;
  logic [2:0] owner_idx_r;
  logic dir_q;
  logic [2:0] chan_q;
  logic [31:0] addr_q;
  // a channel keeps the bus from its grant until block done or stop
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      owner_r <= 1'b0;
      owner_idx_r <= 3'h0;
    end
    else if (!owner_r && gnt_valid)
    begin
      owner_r <= 1'b1;
      owner_idx_r <= gnt_idx;
    end
    else if (owner_r && BEAT_DONE_I &&
             (BLOCK_DONE_I || !on_r[owner_idx_r]))
      owner_r <= 1'b0;
  end
  assign GNT_VALID_O = owner_r;
  assign GNT_CH_O = owner_idx_r;
  assign req = on_r & xfer_r;
  rank_arbiter #(.N(NCH)) u_arb (
    .req_i(req),
    .rank_i(rank_r),
    .gnt_valid_o(gnt_valid),
    .gnt_idx_o(gnt_idx)
  );
  access_capture u_cap (
    .clk_i(CLOCK_I),
    .rst_b_i(RST_B_I),
    .acc_i(owner_r && BEAT_DONE_I),
    .acc_read_i(BEAT_READ_I),
    .acc_chan_i(owner_idx_r),
    .acc_addr_i(BEAT_ADDR_I),
    .dir_o(dir_q),
    .chan_o(chan_q),
    .addr_o(addr_q)
  );
  // ==========================================================
  // per-channel control
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic chain_hit;
      logic ev_ok;
      assign done_pulse[g] = owner_r && BEAT_DONE_I && BLOCK_DONE_I &&
                             owner_idx_r == 3'(g);
      assign ctl_wr[g] = WR_I &&
        ADDR_I == 8'(CHAN_CTRL_BASE + CHAN_CTRL_STRIDE * 8'(g));
      if (g == 0)
      begin : g_lo
        assign chain_hit = permit_r[g] && chain_dir_r[g]
                           && done_pulse[g+1];
      end
      else if (g == NCH-1)
      begin : g_hi
        assign chain_hit = permit_r[g] && !chain_dir_r[g]
                           && done_pulse[g-1];
      end
      else
      begin : g_mid
        assign chain_hit = permit_r[g] &&
          (chain_dir_r[g] ? done_pulse[g+1] : done_pulse[g-1]);
        chain_dn_a: assert property (@(posedge CLOCK_I)
          disable iff (!RST_B_I)
          (permit_r[g] && chain_dir_r[g] && done_pulse[g+1] && !ctl_wr[g])
          |=> on_r[g])
          else $error("lower neighbour did not chain");
      end
      assign ev_ok = on_r[g] || evoff_r[g];
      always_ff @(posedge CLOCK_I or negedge RST_B_I)
      begin
        if (!RST_B_I)
        begin
          on_r[g] <= CTRL_RESET[CHANNEL_ON_BIT];
          chain_dir_r[g] <= CTRL_RESET[CHAIN_DIR_BIT];
          evoff_r[g] <= CTRL_RESET[EVENTS_OFF_BIT];
          permit_r[g] <= CTRL_RESET[CHAIN_PERMIT_BIT];
          auto_r[g] <= CTRL_RESET[AUTO_REEN_BIT];
          rank_r[2*g +: 2] <= CTRL_RESET[RANK_LSB +: 2];
        end
        else
        begin
          if (ctl_wr[g])
          begin
            on_r[g] <= WDATA_I[CHANNEL_ON_BIT];
            chain_dir_r[g] <= WDATA_I[CHAIN_DIR_BIT];
            evoff_r[g] <= WDATA_I[EVENTS_OFF_BIT];
            permit_r[g] <= WDATA_I[CHAIN_PERMIT_BIT];
            auto_r[g] <= WDATA_I[AUTO_REEN_BIT];
            rank_r[2*g +: 2] <= WDATA_I[RANK_LSB +: 2];
          end
          else if (chain_hit)
            on_r[g] <= 1'b1;
          else if (done_pulse[g] && !auto_r[g])
            on_r[g] <= 1'b0;
        end
      end
      // transfer pending: start event arms, abort or block end clears
      always_ff @(posedge CLOCK_I or negedge RST_B_I)
      begin
        if (!RST_B_I)
        begin
          xfer_r[g] <= 1'b0;
          seen_r[g] <= 1'b0;
        end
        else
        begin
          if (ev_ok && ABORT_EV_I[g])
            xfer_r[g] <= 1'b0;
          else if (ev_ok && START_EV_I[g])
            xfer_r[g] <= 1'b1;
          else if (done_pulse[g])
            xfer_r[g] <= 1'b0;
          // an event in the block-end cycle keeps the flag set
          if (ev_ok && (START_EV_I[g] || ABORT_EV_I[g]))
            seen_r[g] <= 1'b1;
          else if (done_pulse[g] || (ev_ok && ABORT_EV_I[g]))
            seen_r[g] <= 1'b0;
        end
      end
      // busy while enabled or still holding the bus
      assign BUSY_O[g] = on_r[g] ||
                         (owner_r && owner_idx_r == 3'(g));
      // ========================================================
      // per-channel checks
      // ========================================================
      auto_keep_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        (done_pulse[g] && auto_r[g] && on_r[g] && !ctl_wr[g]) |=> on_r[g])
        else $error("enable dropped with auto reenable");
      events_off_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        (!on_r[g] && !evoff_r[g] && !seen_r[g]) |=> !seen_r[g])
        else $error("event taken while disabled");
      abort_clear_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        (ev_ok && ABORT_EV_I[g]) |=> !xfer_r[g])
        else $error("abort left transfer armed");
      rank_pick_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        (gnt_valid && req[g]) |-> rank_r[2*g +: 2] <= rank_r[2*gnt_idx +: 2])
        else $error("lower rank won arbitration");
      busy_off_a: assert property (@(posedge CLOCK_I)
        disable iff (!RST_B_I)
        (!on_r[g] && !owner_r) |-> !BUSY_O[g])
        else $error("active flag high while idle");
    end
  endgenerate
  // ==========================================================
  // register read port
  // ==========================================================
  function automatic logic [31:0] ctrl_word(input int c);
    logic [31:0] w;
    w = 32'h0;
    w[ACTIVE_FLAG_BIT] = BUSY_O[c];
    w[CHAIN_DIR_BIT] = chain_dir_r[c];
    w[CHANNEL_ON_BIT] = on_r[c];
    w[EVENTS_OFF_BIT] = evoff_r[c];
    w[CHAIN_PERMIT_BIT] = permit_r[c];
    w[AUTO_REEN_BIT] = auto_r[c];
    w[EVENT_SEEN_BIT] = seen_r[c];
    w[RANK_LSB +: 2] = rank_r[2*c +: 2];
    return w;
  endfunction : ctrl_word
  always_ff @(posedge CLOCK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      RDATA_O <= 32'h0;
    else if (RD_I)
    begin
      RDATA_O <= 32'h0;
      if (ADDR_I == ENGINE_STATUS_OFS)
        RDATA_O <= {28'h0, dir_q, chan_q};
      else if (ADDR_I == LAST_LOCATION_OFS)
        RDATA_O <= addr_q;
      else
        for (int c = 0; c < NCH; c++)
          if (ADDR_I == 8'(CHAN_CTRL_BASE + CHAN_CTRL_STRIDE * 8'(c)))
            RDATA_O <= ctrl_word(c);
    end
    else
      RDATA_O <= 32'h0;
  end
  // ==========================================================
  // checks
  // ==========================================================
  busy_when_on_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    on_r[0] |-> BUSY_O[0])
    else $error("active flag low while enabled");
  suspend_waits_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (owner_r && !BEAT_DONE_I) |=> owner_r)
    else $error("bus released mid transfer");
  suspend_ends_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (owner_r && BEAT_DONE_I && !on_r[owner_idx_r]) |=> !owner_r)
    else $error("bus kept after suspend");
  auto_clear_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (done_pulse[0] && !auto_r[0] && !ctl_wr[0] && !g_ch[0].chain_hit)
    |=> !on_r[0])
    else $error("enable kept without auto reenable");
  chain_guard_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (!permit_r[1] && !on_r[1] && !ctl_wr[1]) |=> !on_r[1])
    else $error("chained without permit");
  chain_up_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (permit_r[1] && !chain_dir_r[1] && done_pulse[0] && !ctl_wr[1])
    |=> on_r[1])
    else $error("higher neighbour did not chain");
  grant_next_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (!owner_r && req != '0) |=> owner_r && owner_idx_r == $past(gnt_idx))
    else $error("free bus not granted");
  read_zero_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (RD_I && ADDR_I != LAST_LOCATION_OFS) |=> RDATA_O[31:16] == 16'h0)
    else $error("upper half not zero");
  status_dir_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (owner_r && BEAT_DONE_I) |=> dir_q == $past(BEAT_READ_I))
    else $error("direction not captured");
  chan_id_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (owner_r && BEAT_DONE_I) |=> chan_q == $past(owner_idx_r))
    else $error("channel number not captured");
  seen_set_a: assert property (@(posedge CLOCK_I)
    disable iff (!RST_B_I)
    (on_r[0] && START_EV_I[0] && !done_pulse[0]) |=> seen_r[0])
    else $error("event not flagged");
  block_cov: cover property (@(posedge CLOCK_I) done_pulse[0]);
  chain_cov: cover property (@(posedge CLOCK_I) g_ch[1].chain_hit);
  suspend_cov: cover property (@(posedge CLOCK_I)
    owner_r && !on_r[owner_idx_r]);
  contest_cov: cover property (@(posedge CLOCK_I)
    !owner_r && $countones(req) > 1);
endmodule : dma_channel_ctrl

// ===== verilog/dma_status_pkg.sv
package dma_status_pkg;
  // ==========================================================
  // register map (word offsets chosen locally, byte address)
  // ==========================================================
  localparam logic [7:0] ENGINE_STATUS_OFS = 8'h00;
  localparam logic [7:0] LAST_LOCATION_OFS = 8'h04;
  localparam logic [7:0] CHAN_CTRL_BASE = 8'h10;
  localparam logic [7:0] CHAN_CTRL_STRIDE = 8'h04;
  // ==========================================================
  // channel control fields
  // ==========================================================
  localparam int ACTIVE_FLAG_BIT = 15;
  localparam int CHAIN_DIR_BIT = 8;
  localparam int CHANNEL_ON_BIT = 7;
  localparam int EVENTS_OFF_BIT = 6;
  localparam int CHAIN_PERMIT_BIT = 5;
  localparam int AUTO_REEN_BIT = 4;
  localparam int EVENT_SEEN_BIT = 2;
  localparam int RANK_LSB = 0;
  localparam int DIRECTION_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam int NUM_CHANNELS = 8;
  typedef enum logic [1:0]
  {
    CH_IDLE = 2'b00,
    CH_XFER = 2'b01
  } chan_state_t;
endpackage : dma_status_pkg

// ===== verilog/rank_arbiter.sv
`timescale 1ns/10ps
module rank_arbiter
  import dma_status_pkg::*;
#(
  parameter int N = 8
)
(
  input wire logic [N-1:0] req_i, // requesting channels
  input wire logic [2*N-1:0] rank_i, // two-bit rank per channel
  output logic gnt_valid_o, // some channel granted
  output logic [2:0] gnt_idx_o // granted channel
);
  // the grant index is three bits wide
  if (N < 1 || N > 8)
  begin : g_bad_n
    $error("arbiter serves 1..8 requesters");
  end
  // highest rank wins, lower index breaks a tie
  always_comb
  begin
    logic [1:0] best;
    best = 2'h0;
    gnt_valid_o = 1'b0;
    gnt_idx_o = 3'h0;
    for (int i = 0; i < N; i++)
    begin
      if (req_i[i] && (!gnt_valid_o || rank_i[2*i +: 2] > best))
      begin
        gnt_valid_o = 1'b1;
        gnt_idx_o = 3'(i);
        best = rank_i[2*i +: 2];
      end
    end
  end
endmodule : rank_arbiter

// ===== verilog/access_capture.sv
`timescale 1ns/10ps
module access_capture
  import dma_status_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_b_i, // async reset, low
  input wire logic acc_i, // bus access beat
  input wire logic acc_read_i, // 1 = read
  input wire logic [2:0] acc_chan_i, // channel doing it
  input wire logic [31:0] acc_addr_i, // address
  output logic dir_o, // last direction
  output logic [2:0] chan_o, // last channel
  output logic [31:0] addr_o // last address
);
  // all three fields load on the same beat
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dir_o <= 1'b0;
      chan_o <= 3'h0;
      addr_o <= ADDR_RESET;
    end
    else if (acc_i)
    begin
      dir_o <= acc_read_i;
      chan_o <= acc_chan_i;
      addr_o <= acc_addr_i;
    end
  end
  capture_tied_a: assert property (@(posedge clk_i)
    disable iff (!rst_b_i)
    acc_i |=> addr_o == $past(acc_addr_i) && chan_o == $past(acc_chan_i)
      && dir_o == $past(acc_read_i))
    else $error("status fields not loaded together");
endmodule : access_capture

// ===== verification/bus_partner.sv
`timescale 1ns/10ps
// ==========================================================
// far side: answers each grant with beats after a set wait
// ==========================================================
module bus_partner
(
  input wire logic clk_i, // clock
  input wire logic rst_b_i, // async reset, low
  input wire logic gnt_i, // grant seen
  input wire logic [2:0] ch_i, // granted channel
  input wire logic [7:0] wait_i, // idle cycles before a beat
  input wire logic [5:0] beats_i, // beats per block
  output logic done_o, // beat done pulse
  output logic read_o, // beat was a read
  output logic last_o, // beat ends block
  output logic [31:0] addr_o // beat address
);
  logic [7:0] cnt_r;
  logic [5:0] beat_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {done_o, read_o, last_o, addr_o, cnt_r, beat_r} <= '0;
    end
    else if (gnt_i && !done_o && cnt_r == wait_i)
    begin
      done_o <= 1'h1;
      read_o <= ch_i[0];
      last_o <= beat_r == beats_i - 6'h01;
      addr_o <= {8'ha5, 13'h0000, ch_i, beat_r, 2'h0};
      beat_r <= (beat_r == beats_i - 6'h01) ? 6'h00 : beat_r + 6'h01;
      cnt_r <= 8'h00;
    end
    else
    begin
      // done and last clear between beats; read and address invert on every cycle without a beat
      done_o <= 1'h0;
      last_o <= 1'h0;
      read_o <= ~read_o;
      addr_o <= ~addr_o;
      cnt_r <= (gnt_i && !done_o) ? cnt_r + 8'h01 : 8'h00;
      beat_r <= gnt_i ? beat_r : 6'h00;
    end
  end
endmodule : bus_partner

// ===== verification/dma_status_and_channel_control_test.sv
`timescale 1ns/10ps
module dma_status_and_channel_control_test;
  import dma_status_pkg::*;
  localparam logic [31:0] ON = 32'h1 << CHANNEL_ON_BIT;
  localparam logic [31:0] AUTO = 32'h1 << AUTO_REEN_BIT;
  localparam logic [31:0] EVO = 32'h1 << EVENTS_OFF_BIT;
  localparam logic [31:0] PERM = 32'h1 << CHAIN_PERMIT_BIT;
  localparam logic [31:0] CDIR = 32'h1 << CHAIN_DIR_BIT;
  localparam logic [31:0] SEEN = 32'h1 << EVENT_SEEN_BIT;
  localparam logic [31:0] BSY = 32'h1 << ACTIVE_FLAG_BIT;
  logic clk, rst_b, wr, rd, bdone, bread, blast, gnt;
  logic [7:0] addr, start, abort, busy, wt;
  logic [31:0] wdata, rdata, baddr, cfg;
  logic [2:0] gch;
  logic [5:0] nb, t;
  logic [5:0] tbl [5] = '{6'h11, 6'h30, 6'h35, 6'h00, 6'h14};
  int fail_count, checks, cyc;
  dma_channel_ctrl u_dma_channel_ctrl (.CLOCK_I(clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .START_EV_I(start), .ABORT_EV_I(abort), .BEAT_DONE_I(bdone),
    .BEAT_READ_I(bread), .BEAT_ADDR_I(baddr), .BLOCK_DONE_I(blast),
    .GNT_VALID_O(gnt), .GNT_CH_O(gch), .BUSY_O(busy));
  bus_partner u_bus_partner (.clk_i(clk), .rst_b_i(rst_b), .gnt_i(gnt),
    .ch_i(gch), .wait_i(wt), .beats_i(nb), .done_o(bdone), .read_o(bread),
    .last_o(blast), .addr_o(baddr));
  always #2 clk = ~clk;
  // ========================================================
  // run limit
  // ========================================================
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ========================================================
  // access tasks
  // ========================================================
  function automatic logic [7:0] cad(input int c);
    return CHAN_CTRL_BASE + CHAN_CTRL_STRIDE * 8'(c);
  endfunction : cad
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wrt
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rdc
  task pulse(input logic [7:0] s, input logic [7:0] a);
    @(posedge clk);
    start <= s;
    abort <= a;
    @(posedge clk);
    start <= 8'h00;
    abort <= 8'h00;
  endtask : pulse
  task grab(input logic [2:0] c);
    for (int i = 0; i < 20 && gnt !== 1'h1; i++) @(negedge clk);
    chk({28'h0, gnt, gch}, {28'h0, 1'h1, c});
  endtask : grab
  task free();
    for (int i = 0; i < 300 && gnt !== 1'h0; i++) @(negedge clk);
  endtask : free
  task run(input logic [2:0] c);
    pulse(8'h01 << c, 8'h00);
    grab(c);
    free();
  endtask : run
  task test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // ========================================================
  // tests
  // ========================================================
  initial
  begin
    {clk, rst_b, wr, rd, addr, start, abort, wdata} = '0;
    wt = 8'h14;
    nb = 6'h02;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    rdc(ENGINE_STATUS_OFS, 32'h0);
    rdc(LAST_LOCATION_OFS, ADDR_RESET);
    for (int c = 0; c < 8; c++) rdc(cad(c), CTRL_RESET);
    wrt(8'hf0, '1);
    rdc(8'hf0, 32'h0);
    wrt(ENGINE_STATUS_OFS, '1);
    rdc(ENGINE_STATUS_OFS, 32'h0);
    wrt(cad(6), '1);
    rdc(cad(6), BSY | CDIR | ON | EVO | PERM | AUTO | 32'h3);
    chk(32'(busy), 32'h40);
    wrt(cad(6), 32'h0);
    rdc(cad(6), 32'h0);
    $display("test registers done");
    wrt(cad(3), ON | 32'h2);
    pulse(8'h08, 8'h00);
    grab(3'h3);
    rdc(cad(3), BSY | ON | SEEN | 32'h2);
    free();
    rdc(ENGINE_STATUS_OFS, 32'hb);
    rdc(LAST_LOCATION_OFS, {8'ha5, 13'h0, 3'h3, 6'h01, 2'h0});
    rdc(cad(3), 32'h2);
    wrt(cad(2), ON | AUTO);
    run(3'h2);
    rdc(ENGINE_STATUS_OFS, 32'h2);
    rdc(cad(2), BSY | ON | AUTO);
    wrt(cad(2), 32'h0);
    $display("test transfer done");
    pulse(8'h20, 8'h00);
    rdc(cad(5), 32'h0);
    wrt(cad(5), EVO);
    pulse(8'h20, 8'h00);
    rdc(cad(5), EVO | SEEN);
    pulse(8'h00, 8'h20);
    rdc(cad(5), EVO | SEEN);
    wrt(cad(5), ON);
    repeat (3) @(negedge clk);
    chk({31'h0, gnt}, 32'h0);
    wrt(cad(5), 32'h0);
    $display("test events done");
    wt = 8'h02;
    for (int i = 0; i < 5; i++)
    begin
      t = tbl[i];
      cfg = (t[5] ? CDIR : 32'h0) | (t[4] ? PERM : 32'h0);
      wrt(cad(1), cfg);
      wrt(cad(t[3:1]), ON);
      run(t[3:1]);
      rdc(cad(1), cfg | (t[0] ? (ON | BSY) : 32'h0));
      wrt(cad(1), 32'h0);
    end
    $display("test chain done");
    for (int k = 0; k < 2; k++)
    begin
      wrt(cad(2), ON | (k ? 32'h3 : 32'h1));
      wrt(cad(5), ON | (k ? 32'h1 : 32'h3));
      pulse(8'h24, 8'h00);
      grab(k ? 3'h2 : 3'h5);
      free();
      grab(k ? 3'h5 : 3'h2);
      free();
    end
    $display("test rank done");
    wt = 8'h0a;
    nb = 6'h04;
    wrt(cad(4), ON);
    pulse(8'h10, 8'h00);
    grab(3'h4);
    wrt(cad(4), 32'h0);
    rdc(cad(4), BSY | SEEN);
    for (int i = 0; i < 60 && busy[4] !== 1'h0; i++) @(negedge clk);
    chk({31'h0, gnt}, 32'h0);
    rdc(LAST_LOCATION_OFS, {8'ha5, 13'h0, 3'h4, 6'h00, 2'h0});
    $display("test suspend done");
    test_done();
  end
endmodule : dma_status_and_channel_control_test
